/* src/flash_iap_page_programmer.sv */
`timescale 1ns/1ps
`include "flash_iap_params.svh"
module flash_iap_page_programmer
	import flash_iap_pkg::*;
#(
	parameter logic [15:0] KEY1          = 16'h1234, // Arbitrary
	parameter logic [15:0] KEY2          = 16'h5678, // Arbitrary
	parameter logic [15:0] KEY3          = 16'h9ABC, // Arbitrary
	parameter int          ENABLE_CYCLES = `ENABLE_WINDOW_CYCLES
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [7:0]             awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire logic [7:0]             araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	output logic                        flash_req,
	output flash_op_type                flash_op,
	output logic [`ADDR_BITS-1:0]       flash_addr,
	output logic [`WORD_BITS-1:0]       flash_wdata,
	input  wire logic [`WORD_BITS-1:0]  flash_rdata,
	input  wire logic                   flash_done,
	output logic                        cpu_stall,
	output logic                        chip_reset
);
	function automatic logic [3:0] reg_index(input logic [7:0] a);
		if (a[1:0] != 2'b00 || a[7:2] > {2'b00, `IDX_DATA_LAST}) begin
			return `IDX_NONE;
		end
		return a[5:2];
	endfunction

	function automatic logic [1:0] pair_of(input logic [3:0] idx);
		logic [3:0] rel;
		rel = idx - `IDX_DATA_FIRST;
		return rel[2:1];
	endfunction

	wbuf_if #(.WORDS(`PAGE_WORDS), .WIDTH(`WORD_BITS)) wbuf ();

	page_buffer #(.WORDS(`PAGE_WORDS), .WIDTH(`WORD_BITS)) u_buffer (
		.clk (clk),
		.bus (wbuf.mem)
	);

	// Bus holding registers
	logic                     aw_held_r;
	logic                     w_held_r;
	logic [7:0]               awaddr_r;
	logic [7:0]               wbyte_r;
	logic                     wlane_r;
	// Software-visible state
	logic                     enabled_r;
	logic [2:0]               mode_r;
	logic                     trigger_r;
	logic                     write_init_r;
	logic                     read_en_r;
	logic                     read_init_r;
	logic [7:0]               key_r;
	logic                     clear_req_r;
	logic [`ADDR_BITS-1:0]    addr_r;
	logic [7:0]               lo_r [4];
	logic [7:0]               hi_r [4];
	logic [15:0]              timer_r;
	// Sequencer
	seq_state_type            state_r;
	seq_state_type            state_nxt;
	logic [`OFFSET_BITS-1:0]  idx_r;
	logic                     auto_clr_r;
	logic                     fin_write;
	logic                     fin_read;
	logic                     fin_clear;

	logic                     wr_go;
	logic                     wr_en;
	logic [3:0]               wr_idx;
	logic                     ctrl_wr;
	logic                     load_word;
	logic                     key_match;
	logic                     timeout;
	logic                     read_hit;

	assign wr_go     = aw_held_r && w_held_r && !bvalid;
	assign wr_idx    = reg_index(awaddr_r);
	assign wr_en     = wr_go && wlane_r;
	assign ctrl_wr   = wr_en && wr_idx == `IDX_CONTROL;
	assign load_word = wr_en && wr_idx == `IDX_DATA0_HI && enabled_r
		&& state_r == ST_IDLE;
	assign key_match = trigger_r && mode_r == MODE_ENABLE
		&& {hi_r[1], lo_r[1]} == KEY1
		&& {hi_r[2], lo_r[2]} == KEY2
		&& {hi_r[3], lo_r[3]} == KEY3;
	assign timeout   = trigger_r && timer_r == 16'(ENABLE_CYCLES - 1);
	assign read_hit  = state_r == ST_READ && flash_done;

	// Write address channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held_r <= 1'b0;
			awready   <= 1'b0;
			awaddr_r  <= 8'h00;
		end else if (wr_go) begin
			aw_held_r <= 1'b0;
			awready   <= 1'b0;
		end else if (awvalid && awready) begin
			aw_held_r <= 1'b1;
			awready   <= 1'b0;
			awaddr_r  <= awaddr;
		end else if (!aw_held_r && !bvalid) begin
			// No new address while a response still waits
			awready   <= 1'b1;
		end
	end

	// Write data channel; registers are byte wide, lane 0 only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w_held_r <= 1'b0;
			wready   <= 1'b0;
			wbyte_r  <= 8'h00;
			wlane_r  <= 1'b0;
		end else if (wr_go) begin
			w_held_r <= 1'b0;
			wready   <= 1'b0;
		end else if (wvalid && wready) begin
			w_held_r <= 1'b1;
			wready   <= 1'b0;
			wbyte_r  <= wdata[7:0];
			wlane_r  <= wstrb[0];
		end else if (!w_held_r && !bvalid) begin
			wready   <= 1'b1;
		end
	end

	// Write response
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			bvalid <= 1'b1;
			bresp  <= (wr_idx == `IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read channel
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rresp   <= `RESP_OKAY;
			rdata   <= 32'h0000_0000;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `RESP_OKAY;
			rdata   <= 32'h0000_0000;
			case (reg_index(araddr))
				`IDX_CONTROL: begin
					rdata[7:0] <= {enabled_r, mode_r, trigger_r,
						write_init_r, read_en_r, read_init_r};
				end
				`IDX_RESET_KEY: begin
					rdata[7:0] <= key_r;
				end
				`IDX_BUF_CLEAR: begin
					rdata[`CLEAR_REQ_BIT] <= clear_req_r;
				end
				`IDX_ADDR_LO: begin
					rdata[7:0] <= addr_r[7:0];
				end
				`IDX_ADDR_HI: begin
					rdata[`ADDR_HI_BITS-1:0] <= addr_r[`ADDR_BITS-1:8];
				end
				`IDX_NONE: begin
					rresp <= `RESP_SLVERR;
				end
				default: begin
					if (araddr[2]) begin
						rdata[7:0] <= lo_r[pair_of(araddr[5:2])];
					end else begin
						rdata[7:0] <= hi_r[pair_of(araddr[5:2])];
					end
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	// Enabled flag and mode; the hardware set wins over a clearing write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enabled_r <= 1'b0;
			mode_r    <= MODE_WRITE;
			read_en_r <= 1'b0;
		end else begin
			if (key_match) begin
				enabled_r <= 1'b1;
			end else if (ctrl_wr && !wbyte_r[`CTRL_ENABLED_BIT]) begin
				enabled_r <= 1'b0;
			end
			if (ctrl_wr) begin
				mode_r    <= wbyte_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
				read_en_r <= wbyte_r[`CTRL_RDEN_BIT];
			end
		end
	end

	// Enable procedure trigger and its window timer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trigger_r <= 1'b0;
			timer_r   <= 16'h0000;
		end else if (ctrl_wr && wbyte_r[`CTRL_TRIGGER_BIT]) begin
			trigger_r <= 1'b1;
			timer_r   <= 16'h0000;
		end else if (key_match || timeout) begin
			trigger_r <= 1'b0;
			timer_r   <= 16'h0000;
		end else if (trigger_r) begin
			timer_r   <= timer_r + 16'h0001;
		end
	end

	// Busy bits: software may only set them, hardware clears on finish
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			write_init_r <= 1'b0;
			read_init_r  <= 1'b0;
			clear_req_r  <= 1'b0;
		end else begin
			if (ctrl_wr && wbyte_r[`CTRL_WRITE_BIT]) begin
				write_init_r <= 1'b1;
			end else if (fin_write) begin
				write_init_r <= 1'b0;
			end
			if (ctrl_wr && wbyte_r[`CTRL_READ_BIT]) begin
				read_init_r <= 1'b1;
			end else if (fin_read) begin
				read_init_r <= 1'b0;
			end
			if (wr_en && wr_idx == `IDX_BUF_CLEAR && wbyte_r[`CLEAR_REQ_BIT]) begin
				clear_req_r <= 1'b1;
			end else if (fin_clear) begin
				clear_req_r <= 1'b0;
			end
		end
	end

	// Chip reset key
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			key_r      <= `BYTE_RESET;
			chip_reset <= 1'b0;
		end else begin
			chip_reset <= wr_en && wr_idx == `IDX_RESET_KEY
				&& wbyte_r == `CHIP_RESET_PATTERN;
			if (wr_en && wr_idx == `IDX_RESET_KEY) begin
				key_r <= wbyte_r;
			end
		end
	end

	// Flash address with auto-increment that stops at the page end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_r <= `ADDR_RESET;
		end else if (wr_en && wr_idx == `IDX_ADDR_LO) begin
			addr_r[7:0] <= wbyte_r;
		end else if (wr_en && wr_idx == `IDX_ADDR_HI) begin
			addr_r[`ADDR_BITS-1:8] <= wbyte_r[`ADDR_HI_BITS-1:0];
		end else if (load_word && addr_r[`OFFSET_BITS-1:0] != `LAST_OFFSET) begin
			addr_r <= addr_r + 13'h0001;
		end
	end

	// Data register pairs; a completed read overrides the first pair
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				lo_r[i] <= `BYTE_RESET;
				hi_r[i] <= `BYTE_RESET;
			end
		end else if (read_hit) begin
			lo_r[0] <= flash_rdata[7:0];
			hi_r[0] <= flash_rdata[15:8];
		end else if (wr_en && wr_idx >= `IDX_DATA_FIRST && wr_idx <= `IDX_DATA_LAST) begin
			if (wr_idx[0]) begin
				lo_r[pair_of(wr_idx)] <= wbyte_r;
			end else begin
				hi_r[pair_of(wr_idx)] <= wbyte_r;
			end
		end
	end

	// Buffer port: clearing walks all words, else software loads
	assign wbuf.we    = state_r == ST_CLEAR || load_word;
	assign wbuf.waddr = (state_r == ST_CLEAR) ? idx_r : addr_r[`OFFSET_BITS-1:0];
	assign wbuf.wdata = (state_r == ST_CLEAR) ? 16'h0000 : {wbyte_r, lo_r[0]};
	assign wbuf.raddr = idx_r;

	always_comb begin
		state_nxt = state_r;
		fin_write = 1'b0;
		fin_read  = 1'b0;
		fin_clear = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (clear_req_r) begin
					state_nxt = ST_CLEAR;
				end else if (write_init_r) begin
					if (enabled_r && mode_r == MODE_WRITE) begin
						state_nxt = ST_WR_FETCH;
					end else if (enabled_r && mode_r == MODE_ERASE) begin
						state_nxt = ST_ERASE;
					end else begin
						fin_write = 1'b1;
					end
				end else if (read_init_r) begin
					if (read_en_r && mode_r == MODE_READ) begin
						state_nxt = ST_READ;
					end else begin
						fin_read = 1'b1;
					end
				end
			end
			ST_WR_FETCH: begin
				state_nxt = ST_WR_ISSUE;
			end
			ST_WR_ISSUE: begin
				state_nxt = ST_WR_WAIT;
			end
			ST_WR_WAIT: begin
				if (flash_done) begin
					state_nxt = (idx_r == `LAST_OFFSET) ? ST_CLEAR : ST_WR_FETCH;
				end
			end
			ST_CLEAR: begin
				if (idx_r == `LAST_OFFSET) begin
					state_nxt = ST_IDLE;
					fin_write = auto_clr_r;
					fin_clear = !auto_clr_r;
				end
			end
			ST_ERASE: begin
				if (flash_done) begin
					state_nxt = ST_IDLE;
					fin_write = 1'b1;
				end
			end
			ST_READ: begin
				if (flash_done) begin
					state_nxt = ST_IDLE;
					fin_read  = 1'b1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r    <= ST_IDLE;
			idx_r      <= '0;
			auto_clr_r <= 1'b0;
			cpu_stall  <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			// A plain buffer clear also holds the CPU; it is short
			cpu_stall <= state_nxt != ST_IDLE;
			if (state_r == ST_IDLE) begin
				idx_r      <= '0;
				auto_clr_r <= 1'b0;
			end else if (state_r == ST_CLEAR) begin
				idx_r <= idx_r + 5'h01;
			end else if (state_r == ST_WR_WAIT && flash_done) begin
				idx_r      <= idx_r + 5'h01;
				auto_clr_r <= idx_r == `LAST_OFFSET;
			end
		end
	end

	// Flash array request, held until done
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flash_req   <= 1'b0;
			flash_op    <= FOP_NONE;
			flash_addr  <= `ADDR_RESET;
			flash_wdata <= 16'h0000;
		end else if (flash_req && flash_done) begin
			flash_req <= 1'b0;
			flash_op  <= FOP_NONE;
		end else if (state_r == ST_WR_ISSUE) begin
			flash_req   <= 1'b1;
			flash_op    <= FOP_WRITE;
			flash_addr  <= {addr_r[`ADDR_BITS-1:`OFFSET_BITS], idx_r};
			flash_wdata <= wbuf.rdata;
		end else if (state_r == ST_IDLE && state_nxt == ST_ERASE) begin
			flash_req  <= 1'b1;
			flash_op   <= FOP_ERASE;
			flash_addr <= {addr_r[`ADDR_BITS-1:`OFFSET_BITS], 5'h00};
		end else if (state_r == ST_IDLE && state_nxt == ST_READ) begin
			flash_req  <= 1'b1;
			flash_op   <= FOP_READ;
			flash_addr <= addr_r;
		end
	end
endmodule

/* src/flash_iap_params.svh */
`ifndef FLASH_IAP_PARAMS_SVH
`define FLASH_IAP_PARAMS_SVH

// Register indices; byte address is index times REG_STRIDE
`define REG_STRIDE          4
`define IDX_CONTROL         4'h0
`define IDX_RESET_KEY       4'h1
`define IDX_BUF_CLEAR       4'h2
`define IDX_ADDR_LO         4'h3
`define IDX_ADDR_HI         4'h4
`define IDX_DATA_FIRST      4'h5
`define IDX_DATA0_HI        4'h6
`define IDX_DATA_LAST       4'hC
`define IDX_NONE            4'hF

// Control, buffer clear and address register fields
`define CTRL_ENABLED_BIT    7
`define CTRL_MODE_HI        6
`define CTRL_MODE_LO        4
`define CTRL_TRIGGER_BIT    3
`define CTRL_WRITE_BIT      2
`define CTRL_RDEN_BIT       1
`define CTRL_READ_BIT       0
`define CLEAR_REQ_BIT       0
`define ADDR_HI_BITS        5

// Reset values
`define CTRL_RESET          8'h00
`define BYTE_RESET          8'h00
`define ADDR_RESET          13'h0000

// Flash geometry
`define PAGE_WORDS          32
`define OFFSET_BITS         5
`define WORD_BITS           16
`define ADDR_BITS           13
`define LAST_OFFSET         5'h1F

`define CHIP_RESET_PATTERN  8'h55

// Bus responses
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

// Enable procedure window: longest time, rounds down
`define CLK_PERIOD_PS       5000
`define ENABLE_WINDOW_NS    1000
`define ENABLE_WINDOW_CYCLES ((`ENABLE_WINDOW_NS * 1000) / `CLK_PERIOD_PS)

`endif

/* src/flash_iap_pkg.sv */
package flash_iap_pkg;

	typedef enum logic [2:0] {
		MODE_WRITE  = 3'b000,
		MODE_ERASE  = 3'b001,
		MODE_READ   = 3'b011,
		MODE_ENABLE = 3'b110
	} op_mode_type;

	typedef enum logic [1:0] {
		FOP_NONE  = 2'b00,
		FOP_WRITE = 2'b01,
		FOP_ERASE = 2'b10,
		FOP_READ  = 2'b11
	} flash_op_type;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_WR_FETCH = 3'b001,
		ST_WR_ISSUE = 3'b011,
		ST_WR_WAIT  = 3'b010,
		ST_CLEAR    = 3'b110,
		ST_ERASE    = 3'b100,
		ST_READ     = 3'b101
	} seq_state_type;

endpackage

/* src/wbuf_if.sv */
`timescale 1ns/1ps
interface wbuf_if #(
	parameter int WORDS = 32,
	parameter int WIDTH = 16
);
	logic                     we;
	logic [$clog2(WORDS)-1:0] waddr;
	logic [WIDTH-1:0]         wdata;
	logic [$clog2(WORDS)-1:0] raddr;
	logic [WIDTH-1:0]         rdata;

	modport mem (
		input  we,
		input  waddr,
		input  wdata,
		input  raddr,
		output rdata
	);

	modport user (
		output we,
		output waddr,
		output wdata,
		output raddr,
		input  rdata
	);
endinterface

/* src/page_buffer.sv */
`timescale 1ns/1ps
module page_buffer #(
	parameter int WORDS = 32,
	parameter int WIDTH = 16
) (
	input wire logic clk,
	wbuf_if.mem      bus
);
	logic [WIDTH-1:0] mem_r [WORDS];

	always_ff @(posedge clk) begin
		if (bus.we) begin
			mem_r[bus.waddr] <= bus.wdata;
		end
	end

	// Registered read: data appear one cycle after raddr
	always_ff @(posedge clk) begin
		bus.rdata <= mem_r[bus.raddr];
	end
endmodule

/* bench/flash_iap_checker_assertions.sv */
`timescale 1ns/1ps
module flash_iap_checker
	import flash_iap_pkg::*;
(
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         awready,
	input wire logic         wready,
	input wire logic         bvalid,
	input wire logic [1:0]   bresp,
	input wire logic         bready,
	input wire logic         rvalid,
	input wire logic [31:0]  rdata,
	input wire logic         rready,
	input wire logic         flash_req,
	input wire flash_op_type flash_op,
	input wire logic [12:0]  flash_addr,
	input wire logic [15:0]  flash_wdata,
	input wire logic         flash_done,
	input wire logic         cpu_stall,
	input wire logic         chip_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Last word address handed to the array, to follow the page walk
	logic [12:0] wr_last_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			wr_last_r <= 13'h0000;
		else if (flash_req && flash_done && flash_op == FOP_WRITE)
			wr_last_r <= flash_addr;
	end

	chk_stall_busy: assert property (flash_req |-> cpu_stall)
		else $error("cpu not stalled during flash access");
	chk_req_steady: assert property (flash_req && !flash_done |=>
		flash_req && $stable(flash_addr) && $stable(flash_op) && $stable(flash_wdata))
		else $error("flash request changed before done");
	chk_req_release: assert property (flash_req && flash_done |=> !flash_req)
		else $error("flash request held after done");
	chk_write_step: assert property ($rose(flash_req) && flash_op == FOP_WRITE
		&& flash_addr[4:0] != 5'h00 |-> flash_addr == wr_last_r + 13'h0001)
		else $error("page write skipped a word");
	chk_write_gap: assert property (flash_req && flash_done && flash_op == FOP_WRITE
		|=> !flash_req [*2])
		else $error("page write words too close");
	chk_reset_pulse: assert property (chip_reset |=> !chip_reset)
		else $error("chip reset wider than one cycle");
	chk_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("register read upper bits set");
	chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	chk_write_block: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");

	cover property (flash_req && flash_done && flash_op == FOP_WRITE);
	cover property (flash_req && flash_done && flash_op == FOP_ERASE);
	cover property (flash_req && flash_done && flash_op == FOP_READ);
	cover property (chip_reset);
endmodule

/* bench/tb_flash_iap_page_programmer.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin \
	n_compared++; \
	if ((a) !== (b)) begin \
		err_count++; \
		$display("[FAIL] %0t got %h exp %h", $time, a, b); \
	end \
end
module tb_flash_iap_page_programmer
	import flash_iap_pkg::*;
;
	localparam logic [15:0] K1 = 16'h3C5A, K2 = 16'hA596, K3 = 16'h0FF1; // Arbitrary
	localparam int          EN_CYC = 20;
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, flash_done;
	logic        awready, wready, bvalid, arready, rvalid, flash_req, cpu_stall, chip_reset;
	logic [7:0]  awaddr, araddr, d, pg, pe;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [12:0] flash_addr;
	logic [15:0] flash_wdata, flash_rdata, w;
	logic [15:0] ew[32], wlog[32], keys[3];
	logic [4:0]  off;
	flash_op_type flash_op;
	int          err_count, n_compared, n_wr, n_er, n_rd, n_cr, dly, k, r;

	flash_iap_page_programmer #(.KEY1(K1), .KEY2(K2), .KEY3(K3), .ENABLE_CYCLES(EN_CYC))
	flash_iap_page_programmer_inst (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .flash_req, .flash_op, .flash_addr, .flash_wdata, .flash_rdata,
		.flash_done, .cpu_stall, .chip_reset);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [15:0] rd_word(input logic [12:0] a);
		return {a[7:0], 3'b101, a[12:8]} ^ 16'h5A3C;
	endfunction

	// Flash array stand-in: random latency, records what it is handed
	always @(posedge clk) begin
		if (chip_reset === 1'b1)
			n_cr <= n_cr + 1;
		if (flash_done)
			flash_done <= 1'b0;
		else if (flash_req === 1'b1) begin
			if (dly > 0)
				dly <= dly - 1;
			else begin
				flash_done <= 1'b1;
				flash_rdata <= rd_word(flash_addr);
				dly <= $urandom_range(3, 0);
				if (flash_op == FOP_WRITE) begin
					wlog[flash_addr[4:0]] <= flash_wdata;
					pg <= flash_addr[12:5];
					n_wr <= n_wr + 1;
				end
				if (flash_op == FOP_ERASE) begin
					pe <= flash_addr[12:5];
					n_er <= n_er + 1;
				end
				if (flash_op == FOP_READ)
					n_rd <= n_rd + 1;
			end
		end
	end

	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic timed_out();
		err_count++;
		$display("[FAIL] %0t wait timed out", $time);
		tally_and_finish();
	endtask

	task automatic wr(input logic [3:0] idx, input logic [7:0] v, input logic [1:0] er = 2'b00);
		int i;
		int hold;
		hold = $urandom_range(2, 0);
		@(posedge clk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
				break;
			// Late bready makes the response stand a while
			if (i >= hold)
				bready <= 1'b1;
		end
		bready <= 1'b0;
		if (i == 100)
			timed_out();
		`CHK(bresp, er)
	endtask

	task automatic rd(input logic [3:0] idx, output logic [7:0] v, input logic [1:0] er = 2'b00);
		int i;
		int hold;
		hold = $urandom_range(2, 0);
		@(posedge clk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
				break;
			if (i >= hold)
				rready <= 1'b1;
		end
		rready <= 1'b0;
		if (i == 100)
			timed_out();
		v = rdata[7:0];
		`CHK(rresp, er)
	endtask

	// Busy bits are hardware-cleared; spin on them with a bound
	task automatic poll(input logic [3:0] idx, input int b);
		logic [7:0] v;
		int i;
		for (i = 0; i < 400; i++) begin
			rd(idx, v);
			if (v[b] === 1'b0)
				break;
		end
		if (i == 400)
			timed_out();
	endtask

	initial begin
		void'($urandom(32'hBCBD));
		{rst, awvalid, wvalid, bready, arvalid, rready, flash_done} = 7'h7F & 7'h40;
		{awaddr, araddr, wdata, flash_rdata} = '0;
		wstrb = 4'hF;
		keys = '{K1, K2, K3};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(0, d);
		`CHK(d, 8'h00)
		rd(4'hD, d, 2'b10);
		`CHK(d, 8'h00)
		wr(4'hE, 8'h11, 2'b10);
		wr(0, 8'h80);
		rd(0, d);
		`CHK(d[7], 1'b0)
		wr(6, 8'h12);
		rd(3, d);
		`CHK(d, 8'h00)
		wr(0, 8'h68);
		repeat (EN_CYC + 10) @(posedge clk);
		rd(0, d);
		`CHK(d[7:3], 5'b01100)
		for (k = 0; k < 3; k++) begin
			wr(4'(7 + 2 * k), keys[k][7:0]);
			wr(4'(8 + 2 * k), keys[k][15:8]);
		end
		wr(0, 8'h68);
		rd(0, d);
		`CHK(d[7], 1'b1)
		wr(1, 8'h55);
		wr(1, 8'h54);
		rd(1, d);
		`CHK(d, 8'h54)
		`CHK(n_cr, 1)
		wr(2, 8'h01);
		poll(2, 0);
		w = 16'($urandom);
		wr(3, {w[2:0], 5'h00});
		wr(4, {3'b000, w[7:3]});
		for (k = 0; k < 32; k++) begin
			ew[k] = 16'($urandom);
			wr(5, ew[k][7:0]);
			if (k < 2) begin
				rd(3, d);
				`CHK(d[4:0], k[4:0])
			end
			wr(6, ew[k][15:8]);
		end
		// Extra load at the page end must not move the address
		wr(6, ew[31][15:8]);
		rd(3, d);
		`CHK(d, {w[2:0], 5'h1F})
		rd(4, d);
		`CHK(d, {3'b000, w[7:3]})
		// Erase the target page before programming it
		wr(0, 8'h94);
		poll(0, 2);
		`CHK(pe, w[7:0])
		for (r = 0; r < 2; r++) begin
			if (r == 1) begin
				wr(2, 8'h01);
				poll(2, 0);
			end
			wr(0, 8'h84);
			poll(0, 2);
			`CHK(n_wr, 32 * (r + 1))
			`CHK(pg, w[7:0])
			for (k = 0; k < 32; k++)
				`CHK(wlog[k], (r == 0) ? ew[k] : 16'h0000)
		end
		w = 16'($urandom);
		off = 5'($urandom_range(31, 1));
		wr(3, {w[2:0], off});
		wr(4, {3'b000, w[7:3]});
		wr(0, 8'h94);
		poll(0, 2);
		`CHK(n_er, 2)
		`CHK(pe, w[7:0])
		for (k = 0; k < 3; k++) begin
			wr(0, {1'b1, 3'(2 * k + 2), 4'b0100});
			poll(0, 2);
		end
		wr(0, 8'hF4);
		poll(0, 2);
		wr(0, 8'hB1);
		poll(0, 0);
		`CHK(n_wr + n_er + n_rd, 66)
		wr(0, 8'hB2);
		wr(0, 8'hB3);
		poll(0, 0);
		w = rd_word({w[7:0], off});
		rd(5, d);
		`CHK(d, w[7:0])
		rd(6, d);
		`CHK(d, w[15:8])
		`CHK(n_rd, 1)
		wr(0, 8'h00);
		rd(0, d);
		`CHK(d[7], 1'b0)
		wr(6, 8'hAA);
		rd(3, d);
		`CHK(d[4:0], off)
		tally_and_finish();
	end
endmodule

bind flash_iap_page_programmer flash_iap_checker flash_iap_checker_inst (.clk(clk), .rst(rst),
	.awready(awready), .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready),
	.rvalid(rvalid), .rdata(rdata), .rready(rready), .flash_req(flash_req),
	.flash_op(flash_op), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
	.flash_done(flash_done), .cpu_stall(cpu_stall), .chip_reset(chip_reset));
